// ===== hdl/mss_pkg.sv
// Constants for the multi-segment position sequencer.
// Assumes a 20 MHz control clock and a plain strobe register port.
package mss_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int MS_TIME = 1;
   localparam int CYC_PER_MS = CLK_HZ / 1000 * MS_TIME;
   localparam int MS_PER_S = 1000;
   localparam int NUM_SEG = 16;
   // Nine address bits: sixteen segments of four words need 256 bytes above the base
   localparam logic [8:0] REG_RUN_MODE = 9'h000;
   localparam logic [8:0] REG_FIRST_SEG = 9'h004;
   localparam logic [8:0] REG_LAST_SEG = 9'h008;
   localparam logic [8:0] REG_RESUME = 9'h00C;
   localparam logic [8:0] REG_REF_TYPE = 9'h010;
   localparam logic [8:0] REG_DWELL_UNIT = 9'h014;
   localparam logic [8:0] REG_STATUS = 9'h018;
   localparam logic [8:0] REG_SEG_BASE = 9'h040;
   localparam int SEG_TRAVEL_POS = 0;
   localparam int SEG_SPEED_POS = 1;
   localparam int SEG_RAMP_POS = 2;
   localparam int SEG_DWELL_POS = 3;
   localparam logic [1:0] RUN_MODE_RST = 2'h0;
   localparam logic [4:0] FIRST_SEG_RST = 5'h01;
   localparam logic [4:0] LAST_SEG_RST = 5'h01;
   localparam logic [31:0] TRAVEL_RST = 32'h00002710;
   localparam logic [15:0] SPEED_RST = 16'h0064;
   localparam logic [15:0] RAMP_RST = 16'h0064;
   localparam logic [15:0] DWELL_RST = 16'h0064;
   localparam logic [15:0] SPEED_MAX = 16'h1388;
   localparam logic [31:0] TRAVEL_MIN = 32'h80000001;
   localparam logic [31:0] TRAVEL_MAX = 32'h7FFFFFFE;
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_CYCLE = 2'h1;
   localparam logic [1:0] MODE_INPUT = 2'h2;
   localparam logic [1:0] SRC_MULTI = 2'h1;
   typedef enum logic [2:0] {MSS_IDLE, MSS_ISSUE, MSS_MOVE, MSS_DWELL, MSS_PAUSED} mss_state_t;
endpackage

// ===== hdl/mss_sequencer.sv
// Multi-segment position sequencer: segment tables, run modes, pause and dwell.
// Assumes a motion generator that accepts a target on seg_start_o and reports
// motion_done_i, and host inputs that arrive asynchronously on pins.
// Behaviour
// - Runs only in position control with command source set to multi-segment.
// - Run mode 0 single, 1 cycle, 2 input-selected; range 0..2, reset 0.
// - Single pass advances segment and stops after the end segment.
// - Cycle mode advances segment and repeats rounds without stopping.
// - Input mode runs whichever segment the select inputs currently choose.
// - Start segment 1..16, reset 1, first segment of automatic modes.
// - End segment 1..16, reset 1; automatic modes step ascending start to end.
// - Active select is 1, bit0 is LSB; segment equals code plus one.
// - Enable falling from active to inactive is a pause.
// - Pause discards the remaining command and stops the motor.
// - Resume policy 0 restarts from the segment after the interrupted one.
// - Resume policy 1 restarts from the configured start segment.
// - Reference type 0 makes travel relative to current position.
// - Reference type 1 makes travel absolute from the origin.
// - Wait between segments; unit 0 milliseconds, 1 seconds.
// - Travel is signed -2147483647..2147483646, reset 10000.
// - Speed limit 1..5000 rpm per segment, passed as plateau speed.
// - Ramp time 1..65535 ms per segment, reset 100.
// - Dwell count 1..65535, reset 100, in the selected unit.
`timescale 1ns/1ps
module mss_sequencer
   import mss_pkg::*;
#(
   parameter int MS_CYCLES = CYC_PER_MS
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [8:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire logic position_mode_i,
   input wire logic [1:0] position_command_source_i,
   input wire logic sequencer_run_enable_i,
   input wire logic segment_select_bit0_i,
   input wire logic segment_select_bit1_i,
   input wire logic segment_select_bit2_i,
   input wire logic segment_select_bit3_i,
   input wire logic motion_done_i,
   output logic seg_start_o,
   output logic seg_abort_o,
   output logic [31:0] seg_travel_o,
   output logic seg_absolute_o,
   output logic [15:0] seg_speed_o,
   output logic [15:0] seg_ramp_o,
   output logic [4:0] active_segment_o,
   output logic running_o
);
   logic [1:0] run_mode;
   logic [4:0] first_seg;
   logic [4:0] last_seg;
   logic resume_policy;
   logic ref_type;
   logic dwell_unit;
   logic [31:0] travel_mem [NUM_SEG];
   logic [15:0] speed_mem [NUM_SEG];
   logic [15:0] ramp_mem [NUM_SEG];
   logic [15:0] dwell_mem [NUM_SEG];
   logic [4:0] sync_a;
   logic [4:0] sync_b;
   logic enable_q;
   mss_state_t state;
   logic [3:0] seg_idx;
   logic [31:0] tick_cnt;
   logic [15:0] ms_left;
   logic [15:0] unit_left;
   // Set when a single pass has finished; enable must drop before another round
   // starts, otherwise a held enable would restart the pass at once
   logic round_done;

   // Clamp a written value into a small range
   function automatic logic [4:0] clamp_seg(input logic [31:0] v);
      if (v == 32'h0) begin
         return 5'h01;
      end else if (v > 32'h10) begin
         return 5'h10;
      end
      return v[4:0];
   endfunction

   function automatic logic [15:0] clamp_u16(input logic [31:0] v, input logic [15:0] hi);
      if (v[15:0] == 16'h0) begin
         return 16'h0001;
      end else if (v > {16'h0, hi}) begin
         return hi;
      end
      return v[15:0];
   endfunction

   // Decode of the register port; the segment area ends 256 bytes above its base,
   // so addresses past it read zero instead of aliasing onto segment words
   wire [8:0] seg_off = reg_addr_i - REG_SEG_BASE;
   wire in_seg_area = (reg_addr_i >= REG_SEG_BASE) && !seg_off[8];
   wire [3:0] wr_seg = seg_off[7:4];
   wire [1:0] wr_field = seg_off[3:2];
   wire stopped = (state == MSS_IDLE);
   wire cfg_wr = reg_wr_i && stopped;
   wire s_enable = sync_b[4];
   wire [3:0] sel_code = sync_b[3:0];
   wire allowed = position_mode_i && (position_command_source_i == SRC_MULTI);
   wire go = allowed && s_enable;
   wire go_idle = go && !round_done;
   wire pause_ev = enable_q && !s_enable;
   wire [3:0] first_idx = 4'(first_seg - 5'h01);
   wire [3:0] last_idx = 4'(last_seg - 5'h01);
   wire at_last = (seg_idx == last_idx);
   wire [3:0] after_idx = at_last ? first_idx : 4'(seg_idx + 4'h1);
   wire [3:0] resume_idx = resume_policy ? first_idx : after_idx;
   wire [3:0] start_idx = (run_mode == MODE_INPUT) ? sel_code : first_idx;
   wire tick_ms = (tick_cnt == 32'(MS_CYCLES - 1));
   wire [15:0] unit_ms = dwell_unit ? 16'(MS_PER_S) : 16'h0001;

   // Configuration registers, writable only while stopped
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         run_mode <= RUN_MODE_RST;
         first_seg <= FIRST_SEG_RST;
         last_seg <= LAST_SEG_RST;
         resume_policy <= 1'b0;
         ref_type <= 1'b0;
         dwell_unit <= 1'b0;
      end else if (cfg_wr) begin
         if (reg_addr_i == REG_RUN_MODE && reg_wdata_i <= 32'h2) begin
            run_mode <= reg_wdata_i[1:0];
         end else if (reg_addr_i == REG_FIRST_SEG) begin
            first_seg <= clamp_seg(reg_wdata_i);
         end else if (reg_addr_i == REG_LAST_SEG) begin
            last_seg <= clamp_seg(reg_wdata_i);
         end else if (reg_addr_i == REG_RESUME) begin
            resume_policy <= reg_wdata_i[0];
         end else if (reg_addr_i == REG_REF_TYPE) begin
            ref_type <= reg_wdata_i[0];
         end else if (reg_addr_i == REG_DWELL_UNIT) begin
            dwell_unit <= reg_wdata_i[0];
         end
      end
   end

   // Segment tables; writable any time, travel, speed and ramp taken at the next segment start, dwell when the move ends
   generate
      for (genvar g = 0; g < NUM_SEG; g++) begin : g_seg
         always_ff @(posedge clock_i) begin
            if (!rst_n_i) begin
               travel_mem[g] <= TRAVEL_RST;
               speed_mem[g] <= SPEED_RST;
               ramp_mem[g] <= RAMP_RST;
               dwell_mem[g] <= DWELL_RST;
            end else if (reg_wr_i && in_seg_area && wr_seg == 4'(g)) begin
               if (wr_field == 2'(SEG_TRAVEL_POS)) begin
                  travel_mem[g] <= ($signed(reg_wdata_i) < $signed(TRAVEL_MIN)) ? TRAVEL_MIN :
                     ($signed(reg_wdata_i) > $signed(TRAVEL_MAX)) ? TRAVEL_MAX :
                     reg_wdata_i;
               end else if (wr_field == 2'(SEG_SPEED_POS)) begin
                  speed_mem[g] <= clamp_u16(reg_wdata_i, SPEED_MAX);
               end else if (wr_field == 2'(SEG_RAMP_POS)) begin
                  ramp_mem[g] <= clamp_u16(reg_wdata_i, 16'hFFFF);
               end else begin
                  dwell_mem[g] <= clamp_u16(reg_wdata_i, 16'hFFFF);
               end
            end
         end
      end
   endgenerate

   // Pin synchronisers; first stage is read only by the second
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         sync_a <= 5'h00;
         sync_b <= 5'h00;
         enable_q <= 1'b0;
      end else begin
         sync_a <= {sequencer_run_enable_i, segment_select_bit3_i, segment_select_bit2_i,
                    segment_select_bit1_i, segment_select_bit0_i};
         sync_b <= sync_a;
         enable_q <= s_enable;
      end
   end

   // Read port, data one cycle after the strobe
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      if (reg_addr_i == REG_RUN_MODE) begin
         rd_mux = {30'h0, run_mode};
      end else if (reg_addr_i == REG_FIRST_SEG) begin
         rd_mux = {27'h0, first_seg};
      end else if (reg_addr_i == REG_LAST_SEG) begin
         rd_mux = {27'h0, last_seg};
      end else if (reg_addr_i == REG_RESUME) begin
         rd_mux = {31'h0, resume_policy};
      end else if (reg_addr_i == REG_REF_TYPE) begin
         rd_mux = {31'h0, ref_type};
      end else if (reg_addr_i == REG_DWELL_UNIT) begin
         rd_mux = {31'h0, dwell_unit};
      end else if (reg_addr_i == REG_STATUS) begin
         rd_mux = {24'h0, 3'(state), seg_idx, running_o};
      end else if (in_seg_area) begin
         case (wr_field)
            2'h0: rd_mux = travel_mem[wr_seg];
            2'h1: rd_mux = {16'h0, speed_mem[wr_seg]};
            2'h2: rd_mux = {16'h0, ramp_mem[wr_seg]};
            default: rd_mux = {16'h0, dwell_mem[wr_seg]};
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 32'h0;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rd_mux;
      end else begin
         reg_rdata_o <= 32'h0;
      end
   end

   // Sequencer state machine
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state <= MSS_IDLE;
         seg_idx <= 4'h0;
         seg_start_o <= 1'b0;
         seg_abort_o <= 1'b0;
         seg_travel_o <= 32'h0;
         seg_absolute_o <= 1'b0;
         seg_speed_o <= 16'h0;
         seg_ramp_o <= 16'h0;
         tick_cnt <= 32'h0;
         ms_left <= 16'h0;
         unit_left <= 16'h0;
         round_done <= 1'b0;
      end else begin
         seg_start_o <= 1'b0;
         seg_abort_o <= 1'b0;
         tick_cnt <= tick_ms ? 32'h0 : tick_cnt + 32'h1;
         // A dropped enable re-arms the next round; a finish in the same cycle wins
         if (!s_enable) begin
            round_done <= 1'b0;
         end
         if ((pause_ev || !allowed) && state != MSS_IDLE && state != MSS_PAUSED) begin
            state <= MSS_PAUSED;
            seg_abort_o <= 1'b1;
         end else begin
            case (state)
               MSS_IDLE: begin
                  if (go_idle) begin
                     seg_idx <= start_idx;
                     state <= MSS_ISSUE;
                  end
               end
               MSS_ISSUE: begin
                  seg_travel_o <= travel_mem[seg_idx];
                  seg_absolute_o <= ref_type;
                  seg_speed_o <= speed_mem[seg_idx];
                  seg_ramp_o <= ramp_mem[seg_idx];
                  seg_start_o <= 1'b1;
                  state <= MSS_MOVE;
               end
               MSS_MOVE: begin
                  if (motion_done_i) begin
                     unit_left <= dwell_mem[seg_idx];
                     ms_left <= unit_ms;
                     tick_cnt <= 32'h0;
                     state <= MSS_DWELL;
                  end
               end
               MSS_DWELL: begin
                  if (tick_ms) begin
                     if (ms_left > 16'h1) begin
                        ms_left <= ms_left - 16'h1;
                     end else if (unit_left > 16'h1) begin
                        ms_left <= unit_ms;
                        unit_left <= unit_left - 16'h1;
                     end else if (run_mode == MODE_INPUT) begin
                        seg_idx <= sel_code;
                        state <= MSS_ISSUE;
                     end else if (run_mode == MODE_SINGLE && at_last) begin
                        state <= MSS_IDLE;
                        round_done <= 1'b1;
                     end else begin
                        seg_idx <= after_idx;
                        state <= MSS_ISSUE;
                     end
                  end
               end
               default: begin
                  if (go) begin
                     seg_idx <= (run_mode == MODE_INPUT) ? sel_code : resume_idx;
                     state <= MSS_ISSUE;
                  end
               end
            endcase
         end
      end
   end

   assign active_segment_o = {1'b0, seg_idx} + 5'h01;
   assign running_o = (state != MSS_IDLE) && (state != MSS_PAUSED);

   // Checks
   sequence s_enable_drop;
      enable_q && !s_enable;
   endsequence
   pause_abort_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      s_enable_drop and (state == MSS_MOVE) |=> seg_abort_o && state == MSS_PAUSED)
      else $error("pause did not abort segment");
   gate_run_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $rose(seg_start_o) |-> $past(allowed))
      else $error("segment started without multi-segment source");
   cfg_lock_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !stopped |=> $stable(run_mode) && $stable(first_seg) && $stable(last_seg))
      else $error("setting changed while running");
   mode_range_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      run_mode <= MODE_INPUT)
      else $error("run mode out of range");
   seg_range_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      first_seg >= 5'h01 && first_seg <= 5'h10 && last_seg >= 5'h01 && last_seg <= 5'h10)
      else $error("segment number out of range");
   single_stop_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      state == MSS_DWELL && $past(state) == MSS_DWELL ##1 state == MSS_IDLE && !$past(pause_ev)
      |-> $past(run_mode) == MODE_SINGLE)
      else $error("stopped outside single pass");
   start_first_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      state == MSS_IDLE && go_idle && run_mode != MODE_INPUT |=> seg_idx == $past(first_idx))
      else $error("did not begin at start segment");
   speed_lim_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      seg_start_o |-> seg_speed_o >= 16'h0001 && seg_speed_o <= SPEED_MAX)
      else $error("speed limit out of range");
   issue_start_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      state == MSS_ISSUE && !pause_ev && allowed |=> seg_start_o && seg_absolute_o == $past(ref_type))
      else $error("segment issue wrong");

   // Abort is a single strobe; a held abort would kill the next segment as well
   abort_pulse_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      seg_abort_o |=> !seg_abort_o)
      else $error("abort held longer than one cycle");

   // A finished single pass stays stopped until enable drops
   round_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      state == MSS_IDLE && round_done && s_enable |=> state == MSS_IDLE)
      else $error("single pass restarted without enable drop");

   // Input mode starts at the segment the select code chooses
   input_pick_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      state == MSS_IDLE && go_idle && run_mode == MODE_INPUT |=> seg_idx == $past(sel_code))
      else $error("input mode took wrong segment");

   // Policy 1 resumes from the start segment
   resume_start_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      state == MSS_PAUSED && go && resume_policy && run_mode != MODE_INPUT
      |=> seg_idx == $past(first_idx))
      else $error("resume did not restart at start segment");

   // Last tick of a dwell, when the next segment is chosen
   sequence s_dwell_end;
      state == MSS_DWELL && tick_ms && ms_left <= 16'h1 && unit_left <= 16'h1;
   endsequence

   // Cycle mode wraps from the end segment to the start segment
   cycle_wrap_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      s_dwell_end ##0 (run_mode == MODE_CYCLE && at_last && allowed && !pause_ev)
      |=> seg_idx == $past(first_idx) && state == MSS_ISSUE)
      else $error("cycle mode did not wrap");

   // Dwell loads the unit length chosen by the unit setting
   dwell_load_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      state == MSS_MOVE && motion_done_i && allowed && !pause_ev
      |=> state == MSS_DWELL && ms_left == ($past(dwell_unit) ? 16'(MS_PER_S) : 16'h0001))
      else $error("dwell unit loaded wrong");

   // Ramp time handed over is never zero
   ramp_range_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      seg_start_o |-> seg_ramp_o >= 16'h0001)
      else $error("ramp time out of range");
endmodule

// ===== bench/mss_host_model.sv
// Host controller pins and profile generator stand-in for the sequencer bench.
// Assumes the bench sets its requests just after a rising clock edge.
`timescale 1ns/1ps
module mss_host_model #(
   parameter int DONE_DELAY = 6
) (
   input wire logic clock_i,
   input wire logic enable_req_i,
   input wire logic [3:0] select_req_i,
   input wire logic stall_i,
   input wire logic seg_start_i,
   input wire logic seg_abort_i,
   output logic sequencer_run_enable_o,
   output logic [3:0] select_o,
   output logic motion_done_o
);
   int move_left = 0;
   initial begin
      sequencer_run_enable_o = 1'b0;
      select_o = 4'h0;
      motion_done_o = 1'b0;
   end
   // Pins follow the requests one edge later, like a controller output stage
   always @(posedge clock_i) begin
      sequencer_run_enable_o <= enable_req_i;
      select_o <= select_req_i;
   end
   // Travel takes a fixed time; a stall models a long move that never ends
   always @(posedge clock_i) begin
      motion_done_o <= 1'b0;
      if (seg_abort_i) begin
         move_left <= 0;
      end else if (seg_start_i) begin
         move_left <= DONE_DELAY;
      end else if (move_left > 0 && !stall_i) begin
         move_left <= move_left - 1;
         motion_done_o <= (move_left == 1);
      end
   end
endmodule

// ===== bench/multi_segment_position_sequencer_test.sv
// Self-checking bench for the multi-segment position sequencer.
// Assumes the design is built with MS_CYCLES = 4, so one dwell unit of 1 ms is 4 cycles.
`timescale 1ns/1ps
module multi_segment_position_sequencer_test;
   import mss_pkg::*;
   typedef struct {logic wr; logic [8:0] a; logic [31:0] d; logic [31:0] e;} mss_row_t;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [8:0] reg_addr = 9'h000;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic pos_mode = 1'b1;
   logic [1:0] cmd_src = 2'h1;
   logic en_req = 1'b0;
   logic stall = 1'b0;
   logic [3:0] sel_req = 4'h0;
   wire logic [31:0] rdata, travel;
   wire logic [15:0] speed, ramp;
   wire logic [4:0] seg_o;
   wire logic [3:0] sel;
   wire logic en_pin, done, start, abort_o, absol, running;
   int fail_count = 0;
   int check_count = 0;
   int cyc = 0;
   int n_starts = 0;
   int last_start = 0;
   int gap = 0;
   int n0;
   logic [31:0] got;
   // Reset values, refused writes and clamping; the eleventh read hits an unmapped word
   mss_row_t rows[17] = '{
      '{1'b0, 9'h000, 32'h0, 32'h0}, '{1'b0, 9'h004, 32'h0, 32'h1},
      '{1'b0, 9'h008, 32'h0, 32'h1}, '{1'b0, 9'h00C, 32'h0, 32'h0},
      '{1'b0, 9'h010, 32'h0, 32'h0}, '{1'b0, 9'h014, 32'h0, 32'h0},
      '{1'b0, 9'h040, 32'h0, 32'h2710}, '{1'b0, 9'h044, 32'h0, 32'h64},
      '{1'b0, 9'h048, 32'h0, 32'h64}, '{1'b0, 9'h04C, 32'h0, 32'h64},
      '{1'b0, 9'h01C, 32'h0, 32'h0}, '{1'b1, 9'h000, 32'h3, 32'h0},
      '{1'b1, 9'h004, 32'h0, 32'h1}, '{1'b1, 9'h008, 32'h11, 32'h10},
      '{1'b1, 9'h044, 32'h1770, 32'h1388}, '{1'b1, 9'h048, 32'h0, 32'h1},
      '{1'b1, 9'h040, 32'h80000000, 32'h80000001}};

   initial begin
      forever #25 clock_i = ~clock_i;
   end
   // Start counter and hang guard
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (start === 1'b1) n_starts <= n_starts + 1;
      if (cyc > 40000) begin
         fail_count++;
         finish_test();
      end
   end

   mss_sequencer #(.MS_CYCLES(4)) dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .position_mode_i(pos_mode),
      .position_command_source_i(cmd_src), .sequencer_run_enable_i(en_pin),
      .segment_select_bit0_i(sel[0]), .segment_select_bit1_i(sel[1]),
      .segment_select_bit2_i(sel[2]), .segment_select_bit3_i(sel[3]),
      .motion_done_i(done), .seg_start_o(start), .seg_abort_o(abort_o), .seg_travel_o(travel),
      .seg_absolute_o(absol), .seg_speed_o(speed), .seg_ramp_o(ramp),
      .active_segment_o(seg_o), .running_o(running));
   mss_host_model host (
      .clock_i(clock_i), .enable_req_i(en_req), .select_req_i(sel_req), .stall_i(stall),
      .seg_start_i(start), .seg_abort_i(abort_o), .sequencer_run_enable_o(en_pin),
      .select_o(sel), .motion_done_o(done));

   task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk_flag(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic reg_write(input logic [8:0] a, input logic [31:0] d);
      @(posedge clock_i);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock_i);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [8:0] a, output logic [31:0] d);
      @(posedge clock_i);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock_i);
      reg_rd <= 1'b0;
      @(negedge clock_i);
      d = rdata;
   endtask
   task automatic do_reset();
      en_req <= 1'b0;
      stall <= 1'b0;
      rst_n_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      rst_n_i <= 1'b1;
   endtask
   // Segment n travels n*256 with a dwell of one unit, so every move is identifiable
   task automatic setup(input logic [1:0] mode, input logic [4:0] first, input logic [4:0] last,
                        input logic pol, input logic abs_t, input logic unit);
      do_reset();
      for (int s = 0; s < 16; s++) begin
         reg_write(REG_SEG_BASE + 9'(s * 16), {19'h0, 5'(s + 1), 8'h00});
         reg_write(REG_SEG_BASE + 9'(s * 16 + SEG_DWELL_POS * 4), 32'h1);
      end
      reg_write(REG_RUN_MODE, {30'h0, mode});
      reg_write(REG_FIRST_SEG, {27'h0, first});
      reg_write(REG_LAST_SEG, {27'h0, last});
      reg_write(REG_RESUME, {31'h0, pol});
      reg_write(REG_REF_TYPE, {31'h0, abs_t});
      reg_write(REG_DWELL_UNIT, {31'h0, unit});
   endtask
   task automatic wait_start(input logic [4:0] seg, input logic ab);
      int n;
      @(negedge clock_i);
      for (n = 0; start !== 1'b1 && n < 9000; n++) @(negedge clock_i);
      gap = cyc - last_start;
      last_start = cyc;
      chk_val("segment", {27'h0, seg}, {27'h0, seg_o});
      chk_val("travel", {19'h0, seg, 8'h00}, travel);
      chk_flag("absolute", ab, absol);
   endtask
   task automatic wait_abort();
      int n;
      for (n = 0; abort_o !== 1'b1 && n < 20; n++) @(negedge clock_i);
      chk_flag("abort", 1'b1, abort_o);
      @(negedge clock_i);
      chk_flag("running", 1'b0, running);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      do_reset();
      foreach (rows[i]) begin
         if (rows[i].wr) reg_write(rows[i].a, rows[i].d);
         reg_read(rows[i].a, got);
         chk_val("register", rows[i].e, got);
      end
      $display("register table done");
      // Single pass, absolute targets, wait in seconds
      setup(MODE_SINGLE, 5'd2, 5'd4, 1'b0, 1'b1, 1'b1);
      en_req <= 1'b1;
      wait_start(5'd2, 1'b1);
      chk_val("speed", 32'h64, {16'h0, speed});
      chk_val("ramp", 32'h64, {16'h0, ramp});
      wait_start(5'd3, 1'b1);
      chk_flag("dwell_s", 1'b1, gap >= 4006 && gap <= 4016);
      wait_start(5'd4, 1'b1);
      for (int n = 0; running !== 1'b0 && n < 9000; n++) @(negedge clock_i);
      n0 = n_starts;
      repeat (100) @(posedge clock_i);
      chk_val("stopped", n0, n_starts);
      $display("single pass done");
      // Cycle mode wraps back to the start; settings locked while running
      setup(MODE_CYCLE, 5'd3, 5'd4, 1'b0, 1'b0, 1'b0);
      en_req <= 1'b1;
      wait_start(5'd3, 1'b0);
      wait_start(5'd4, 1'b0);
      chk_flag("dwell_ms", 1'b1, gap >= 10 && gap <= 20);
      wait_start(5'd3, 1'b0);
      reg_write(REG_RUN_MODE, 32'h0);
      reg_read(REG_RUN_MODE, got);
      chk_val("locked mode", 32'h1, got);
      wait_start(5'd4, 1'b0);
      stall <= 1'b1;
      en_req <= 1'b0;
      wait_abort();
      $display("cycle mode done");
      // Pause in the middle of segment 1, then resume under each policy
      for (int p = 0; p < 2; p++) begin
         setup(MODE_SINGLE, 5'd1, 5'd4, 1'(p), 1'b0, 1'b0);
         stall <= 1'b1;
         en_req <= 1'b1;
         wait_start(5'd1, 1'b0);
         repeat (10) @(posedge clock_i);
         en_req <= 1'b0;
         wait_abort();
         stall <= 1'b0;
         en_req <= 1'b1;
         wait_start(p ? 5'd1 : 5'd2, 1'b0);
      end
      $display("pause and resume done");
      // Input-selected mode, after checking that nothing runs outside multi-segment source
      setup(MODE_INPUT, 5'd1, 5'd1, 1'b0, 1'b0, 1'b0);
      pos_mode <= 1'b0;
      en_req <= 1'b1;
      repeat (40) @(posedge clock_i);
      chk_flag("no position mode", 1'b0, running);
      pos_mode <= 1'b1;
      cmd_src <= 2'h2;
      repeat (40) @(posedge clock_i);
      chk_flag("other source", 1'b0, running);
      // Enable must be gone through the synchroniser before the source is restored
      en_req <= 1'b0;
      stall <= 1'b1;
      repeat (6) @(posedge clock_i);
      cmd_src <= SRC_MULTI;
      @(posedge clock_i);
      foreach (rows[i]) begin
         if (i < 4) begin
            sel_req <= (i == 0) ? 4'h0 : (i == 1) ? 4'h1 : (i == 2) ? 4'h5 : 4'hF;
            repeat (4) @(posedge clock_i);
            en_req <= 1'b1;
            wait_start(5'(sel_req) + 5'd1, 1'b0);
            en_req <= 1'b0;
            wait_abort();
         end
      end
      $display("input selection done");
      finish_test();
   end
endmodule
